/* bench/edo_dram_model.sv */
// Behaves as the EDO devices on the far side of the strobes.
module edo_dram_model
(
  input  wire logic        clk_sys,     // Bus clock.
  input  wire logic        resetn,      // Asynchronous reset, active low.
  input  wire logic        ras_board_n, // Row strobe of the on-board bank.
  input  wire logic        ras_simm_n,  // Row strobe of the socket bank.
  input  wire logic        cas_n,       // Column strobe.
  output logic [31:0]      dram_rdata   // Read data back to the block.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] beat_q; // Beat number within the present row access.
  logic [31:0] word;   // Word that the devices put out for this beat.

  ////////////////////////////////////////////////////////////////////////////////
  // Each clock with the column strobe low moves on to the next beat; closing the row starts over.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      beat_q <= 32'h0000_0000;
    else if (ras_board_n && ras_simm_n)
      beat_q <= 32'h0000_0000;
    else if (!cas_n)
      beat_q <= beat_q + 32'h0000_0001;
  end

  // Data is valid only while the column strobe is low; otherwise it is turned over.
  assign word       = 32'hA5A5_0000 + beat_q;
  assign dram_rdata = cas_n ? ~word : word;
endmodule : edo_dram_model

/* bench/edo_dram_ras_steering_tb.sv */
// Drives bursts, sizes and sources into the block and judges its answers.
module edo_dram_ras_steering_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys    = 1'b0;  // Bus clock.
  logic        resetn     = 1'b0;  // Reset, active low.
  logic        req_start  = 1'b0;  // Access request.
  logic        req_write  = 1'b0;  // Write access.
  logic        req_last   = 1'b0;  // Last data phase.
  logic [23:0] req_addr   = 24'h00_0000; // Word address.
  logic [1:0]  req_source = 2'h0;  // Requesting master.
  logic [31:0] wdata      = 32'h0000_0000; // Write data.
  logic [2:0]  size_set   = 3'h0;  // Size setting.
  logic        size_load  = 1'b0;  // Size load pulse.
  logic [31:0] dram_rdata;         // Data from the devices.
  logic        ready_n, ras_board_n, ras_simm_n, cas_n, we_n;
  logic [31:0] rdata, dram_wdata;
  logic [1:0]  owner;
  int          bad_count   = 0;    // Mismatches seen.
  int          comparisons = 0;    // Checks made.

  always #25 clk_sys = ~clk_sys;

  edo_dram_ras_steering i_dut
  (
    .clk_sys(clk_sys), .resetn(resetn), .req_start(req_start), .req_write(req_write),
    .req_last(req_last), .req_addr(req_addr), .req_source(req_source), .wdata(wdata),
    .size_set(size_set), .size_load(size_load), .dram_rdata(dram_rdata),
    .ready_n(ready_n), .rdata(rdata), .dram_wdata(dram_wdata), .ras_board_n(ras_board_n),
    .ras_simm_n(ras_simm_n), .cas_n(cas_n), .we_n(we_n), .owner(owner)
  );

  edo_dram_model i_dram
  (
    .clk_sys(clk_sys), .resetn(resetn), .ras_board_n(ras_board_n),
    .ras_simm_n(ras_simm_n), .cas_n(cas_n), .dram_rdata(dram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask : chk

  // Prints the verdict and stops.
  task automatic test_done;
  begin
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask : test_done

  // Loads a size code as configuration software would.
  task automatic set_size(input logic [2:0] code);
  begin
    @(posedge clk_sys);
    size_set  <= code;
    size_load <= 1'b1;
    @(posedge clk_sys);
    size_load <= 1'b0;
  end
  endtask : set_size

  // Runs one access of n phases; checks timing each clock, and strobes, owner and data in each data phase.
  task automatic access(input logic w, input logic [23:0] a, input logic [1:0] s,
                        input int n, input logic eb, input logic es);
    int first;
    int p;
  begin
    // Edges after the one that takes the request until ready is shown low.
    first = w ? 1 : 2;
    @(posedge clk_sys);
    req_start  <= 1'b1;
    req_write  <= w;
    req_addr   <= a;
    req_source <= s;
    req_last   <= (n == 1);
    wdata      <= 32'h5EED_0000;
    @(posedge clk_sys);
    req_start  <= 1'b0;
    // The edge after the last phase is the one recovery clock.
    for (int j = 1; j <= first + n; j++)
    begin
      @(posedge clk_sys);
      p = j - first;
      if (p >= 0)
      begin
        req_last <= (p + 1 == n - 1);
        wdata    <= 32'h5EED_0000 + 32'(p + 1);
      end
      #1;
      chk({31'h0, ready_n}, {31'h0, !(p >= 0 && p < n)});
      if (p == n && !w)
        chk(rdata, 32'hA5A5_0000 + 32'(n - 1));
      if (p >= 0 && p < n)
      begin
        chk({26'h0, ras_board_n, ras_simm_n, we_n, cas_n, owner},
            {26'h0, eb, es, ~w, 1'b0, s});
        if (w)
          chk(dram_wdata, 32'h5EED_0000 + 32'(p));
        else
          chk(rdata, 32'hA5A5_0000 + 32'(p));
      end
    end
  end
  endtask : access

  // Size codes 1 to 4 each put the board bank right above the module.
  task automatic t_steer;
    logic [3:0] slice;
  begin
    for (int c = 1; c <= 4; c++)
    begin
      set_size(3'(c));
      slice = 4'(1 << (c - 1));
      access(1'b0, {slice, 20'h0_0000}, 2'h0, 1, 1'b0, 1'b1);
      access(1'b0, {slice - 4'h1, 20'hF_FFFF}, 2'h0, 1, 1'b1, 1'b0);
    end
  end
  endtask : t_steer

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, default map, bursts, back-to-back singles, steering.
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk({27'h0, ras_board_n, ras_simm_n, ready_n, cas_n, we_n}, 32'h0000_001F);
    chk({30'h0, owner}, 32'h0000_0000);
    access(1'b0, 24'h0F_FFF0, 2'h1, 4, 1'b0, 1'b1);
    access(1'b1, 24'h00_0100, 2'h2, 4, 1'b0, 1'b1);
    access(1'b0, 24'h00_0004, 2'h0, 1, 1'b0, 1'b1);
    access(1'b1, 24'h00_0008, 2'h1, 1, 1'b0, 1'b1);
    t_steer();
    test_done();
  end
endmodule : edo_dram_ras_steering_tb

/* core/edo_dram_ras_steering.sv */
module edo_dram_ras_steering
(
  input  wire logic        clk_sys,     // Bus clock.
  input  wire logic        resetn,      // Asynchronous reset, active low.
  input  wire logic        req_start,   // Address phase of a new access.
  input  wire logic        req_write,   // High for a write access.
  input  wire logic        req_last,    // High while the current phase is the last.
  input  wire logic [23:0] req_addr,    // Word address of the access.
  input  wire logic [1:0]  req_source,  // Requesting master: local, primary or secondary PCI.
  input  wire logic [31:0] wdata,       // Write data from the bus.
  input  wire logic [2:0]  size_set,    // Size setting from configuration logic.
  input  wire logic        size_load,   // Pulse that loads size_set.
  input  wire logic [31:0] dram_rdata,  // Read data from the DRAM devices.
  output logic             ready_n,     // Data phase done, active low.
  output logic [31:0]      rdata,       // Read data to the bus.
  output logic [31:0]      dram_wdata,  // Write data to the DRAM devices.
  output logic             ras_board_n, // Row strobe of the on-board bank.
  output logic             ras_simm_n,  // Row strobe of the socket bank.
  output logic             cas_n,       // Column strobe.
  output logic             we_n,        // Write enable.
  output logic [1:0]       owner        // Master that owns the present access.
);

  ////////////////////////////////////////////////////////////////////////////
  // State and next values.
  edo_pkg::seq_state_e state_q, state_d;     // Sequencer state.
  logic [2:0]          cnt_q, cnt_d;         // Wait clocks of the first phase left before ready is registered.
  logic                wr_q, wr_d;           // Access is a write.
  logic [2:0]          size_q, size_d;       // Programmed module size.
  logic                ready_n_q, ready_n_d; // Registered ready.
  logic                rb_q, rb_d;           // Registered on-board strobe.
  logic                rs_q, rs_d;           // Registered socket strobe.
  logic                cas_q, cas_d;         // Registered column strobe.
  logic                we_q, we_d;           // Registered write enable.
  logic [31:0]         rd_q, rd_d;           // Registered read data.
  logic [31:0]         wd_q, wd_d;           // Registered write data.
  logic [1:0]          own_q, own_d;         // Registered owner.
  logic                sel_board;            // Steering result for the board bank.
  logic                sel_simm;             // Steering result for the socket bank.

  ////////////////////////////////////////////////////////////////////////////
  // Strobe steering from the request address.
  ras_steer u_steer
  (
    .addr      (req_addr),
    .size_code (size_q),
    .sel_board (sel_board),
    .sel_simm  (sel_simm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next-state logic.
  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    wr_d      = wr_q;
    ready_n_d = 1'b1;
    rb_d      = rb_q;
    rs_d      = rs_q;
    cas_d     = 1'b1;
    we_d      = we_q;
    own_d     = own_q;
    rd_d      = rd_q;
    wd_d      = wd_q;
    // Size setting is only changed by software; reset leaves board only.
    size_d    = size_load ? size_set : size_q;
    case (state_q)
      edo_pkg::ST_IDLE:
      begin
        // Any master is served alike, whatever bus it comes from.
        if (req_start)
        begin
          own_d   = req_source;
          wr_d    = req_write;
          rb_d    = ~sel_board;
          rs_d    = ~sel_simm;
          we_d    = ~req_write;
          // First phase counts down to its ready clock. The address clock and
          // the registered ready each take one clock of the phase.
          cnt_d   = (req_write ? edo_pkg::WRITE_FIRST_CLKS
                               : edo_pkg::READ_FIRST_CLKS) - 3'h3;
          state_d = edo_pkg::ST_WAIT;
        end
      end
      edo_pkg::ST_WAIT:
      begin
        // Wait states of the first phase only.
        if (cnt_q != 3'h0)
        begin
          cnt_d = cnt_q - 3'h1;
          // A read opens the column one clock early, so that the devices
          // drive valid data at the edge that captures them.
          if (!wr_q && cnt_q == 3'h1)
          begin
            cas_d = 1'b0;
          end
        end
        else
        begin
          ready_n_d = 1'b0;
          cas_d     = 1'b0;
          rd_d      = dram_rdata;
          wd_d      = wdata;
          state_d   = req_last ? edo_pkg::ST_RECOV : edo_pkg::ST_DATA;
        end
      end
      edo_pkg::ST_DATA:
      begin
        // Later phases finish every clock with EDO data held.
        ready_n_d = 1'b0;
        cas_d     = 1'b0;
        rd_d      = dram_rdata;
        wd_d      = wdata;
        if (req_last)
        begin
          state_d = edo_pkg::ST_RECOV;
        end
      end
      default:
      begin
        // The single recovery clock, then straight back to idle.
        rb_d    = 1'b1;
        rs_d    = 1'b1;
        we_d    = 1'b1;
        state_d = edo_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q   <= edo_pkg::ST_IDLE;
      cnt_q     <= 3'h0;
      wr_q      <= 1'b0;
      size_q    <= edo_pkg::SIZE_RESET;
      ready_n_q <= 1'b1;
      rb_q      <= 1'b1;
      rs_q      <= 1'b1;
      cas_q     <= 1'b1;
      we_q      <= 1'b1;
      rd_q      <= 32'h0000_0000;
      wd_q      <= 32'h0000_0000;
      own_q     <= 2'h0;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      wr_q      <= wr_d;
      size_q    <= size_d;
      ready_n_q <= ready_n_d;
      rb_q      <= rb_d;
      rs_q      <= rs_d;
      cas_q     <= cas_d;
      we_q      <= we_d;
      rd_q      <= rd_d;
      wd_q      <= wd_d;
      own_q     <= own_d;
    end
  end

  assign ready_n     = ready_n_q;
  assign rdata       = rd_q;
  assign dram_wdata  = wd_q;
  assign ras_board_n = rb_q;
  assign ras_simm_n  = rs_q;
  assign cas_n       = cas_q;
  assign we_n        = we_q;
  assign owner       = own_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_read_first: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req_start && state_q == edo_pkg::ST_IDLE && !req_write) |-> ##3 !ready_n_q)
    else $error("read first phase not four clocks");
  a_read_nofast: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req_start && state_q == edo_pkg::ST_IDLE && !req_write) |-> ##1 ready_n_q [*2])
    else $error("read ready too early");
  a_write_first: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req_start && state_q == edo_pkg::ST_IDLE && req_write) |-> ##1 ready_n_q ##1 !ready_n_q)
    else $error("write first phase not three clocks");
  a_burst_nowait: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == edo_pkg::ST_DATA) |-> ##1 !ready_n_q)
    else $error("wait state inside burst");
  a_one_recov: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == edo_pkg::ST_RECOV) |=> (state_q == edo_pkg::ST_IDLE))
    else $error("more than one recovery clock");
  a_strobe_excl: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(!rb_q && !rs_q))
    else $error("both bank strobes active");
  a_board_top: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req_start && state_q == edo_pkg::ST_IDLE && size_q == edo_pkg::SIZE_32M
     && req_addr[23:20] == 4'h8) |=> !rb_q && rs_q)
    else $error("board bank not above 32 Mbyte module");
  a_reset_board: assert property (@(posedge clk_sys) disable iff (!resetn)
    (size_q == edo_pkg::SIZE_NONE) |-> rs_q)
    else $error("socket strobe with no size set");
  a_data_pass: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == edo_pkg::ST_DATA) |=> rd_q == $past(dram_rdata))
    else $error("read data altered");
  a_cas_lead: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == edo_pkg::ST_WAIT && !wr_q && cnt_q == 3'h0) |-> !cas_q)
    else $error("read data taken with column closed");
  a_owner: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req_start && state_q == edo_pkg::ST_IDLE) |=> own_q == $past(req_source))
    else $error("owner not captured");
  c_read: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_q == edo_pkg::ST_WAIT && !wr_q ##1 state_q == edo_pkg::ST_DATA);
  c_write: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_q == edo_pkg::ST_WAIT && wr_q ##1 state_q == edo_pkg::ST_RECOV);
  c_simm: cover property (@(posedge clk_sys) disable iff (!resetn) !rs_q);
  c_board_top: cover property (@(posedge clk_sys) disable iff (!resetn)
    !rb_q && size_q == edo_pkg::SIZE_32M);

endmodule : edo_dram_ras_steering

/* core/edo_pkg.sv */
package edo_pkg;

  // Bus clock rate in MHz at which the burst timing holds.
  localparam int unsigned BUS_MHZ          = 33;
  // Clocks of the first data phase of a read and of a write.
  localparam logic [2:0]  READ_FIRST_CLKS  = 3'h4;
  localparam logic [2:0]  WRITE_FIRST_CLKS = 3'h3;
  // Clocks of every later data phase of a burst.
  localparam logic [2:0]  BURST_NEXT_CLKS  = 3'h1;
  // Width of the word address seen by the controller (32-bit words, 64 Mbyte span).
  localparam int unsigned ADDR_W           = 24;
  // Lowest address bit of the field that selects a 4 Mbyte slice of the word address.
  localparam int unsigned SLICE_LSB        = 20;
  // Size codes for the module in the socket.
  localparam logic [2:0]  SIZE_NONE        = 3'h0;
  localparam logic [2:0]  SIZE_4M          = 3'h1;
  localparam logic [2:0]  SIZE_8M          = 3'h2;
  localparam logic [2:0]  SIZE_16M         = 3'h3;
  localparam logic [2:0]  SIZE_32M         = 3'h4;
  // Size code after reset.
  localparam logic [2:0]  SIZE_RESET       = 3'h0;

  // Access sequencer states.
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DATA  = 2'b10,
    ST_RECOV = 2'b11
  } seq_state_e;

endpackage : edo_pkg

/* core/ras_steer.sv */
// Maps a word address and the size setting to at most one of two bank strobes.
module ras_steer
(
  input  wire logic [23:0] addr,      // Word address of the access.
  input  wire logic [2:0]  size_code, // Programmed socket module size.
  output logic             sel_board, // On-board bank selected.
  output logic             sel_simm   // Socket bank selected.
);

  // Slice index of the address in 4 Mbyte units.
  logic [3:0] slice;
  // Slice at which the on-board bank sits, just above the module.
  logic [3:0] top_slice;

  assign slice = addr[edo_pkg::ADDR_W - 1:edo_pkg::SLICE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // The on-board bank always takes the slice just above the module.
  always_comb
  begin
    case (size_code)
      edo_pkg::SIZE_4M:  top_slice = 4'h1;
      edo_pkg::SIZE_8M:  top_slice = 4'h2;
      edo_pkg::SIZE_16M: top_slice = 4'h4;
      edo_pkg::SIZE_32M: top_slice = 4'h8;
      default:           top_slice = 4'h0; // Only the on-board bank answers.
    endcase
    sel_board = (slice == top_slice);
    sel_simm  = (slice < top_slice);
  end

endmodule : ras_steer
